//--- core/efts_cfg.svh
`ifndef EFTS_CFG_SVH
`define EFTS_CFG_SVH

// Control type identifications
`define EFTS_TI_FILE_READY 8'h78
`define EFTS_TI_SECTION_READY 8'h79
`define EFTS_TI_CALL 8'h7A
`define EFTS_TI_LAST 8'h7B
`define EFTS_TI_ACK 8'h7C
`define EFTS_TI_SEGMENT 8'h7D
`define EFTS_TI_DIRECTORY 8'h7E

// Event types, variable structure qualifier and file name allowed in the file
`define EFTS_TI_EVT_MIN 8'h1E
`define EFTS_TI_EVT_MAX 8'h28
`define EFTS_VSQ_ONE 8'h01
`define EFTS_NAME_SOE 16'h0003

// Select/call qualifiers
`define EFTS_SCQ_SELECT 8'h01
`define EFTS_SCQ_CALL_FILE 8'h02
`define EFTS_SCQ_DEACT 8'h03
`define EFTS_SCQ_CALL_SEC 8'h06

// Last section/segment qualifiers
`define EFTS_LSQ_LAST_SEC 8'h01
`define EFTS_LSQ_DEACT 8'h02
`define EFTS_LSQ_LAST_SEG 8'h03

// Acknowledge qualifiers
`define EFTS_AFQ_FILE_POS 8'h01
`define EFTS_AFQ_FILE_NEG 8'h02
`define EFTS_AFQ_SEC_POS 8'h03
`define EFTS_AFQ_SEC_NEG 8'h04

// Ready reply qualifiers
`define EFTS_RDY_POS 8'h00
`define EFTS_RDY_NEG 8'h80

// Register offsets
`define EFTS_OFS_CTRL 8'h00
`define EFTS_OFS_LIMIT 8'h04
`define EFTS_OFS_STATUS 8'h08
`define EFTS_OFS_REJECTS 8'h0C
`define EFTS_OFS_ABORTS 8'h10

// Field positions and reset values
`define EFTS_CTRL_EN_BIT 0
`define EFTS_CTRL_FLUSH_BIT 1
`define EFTS_EN_RST 1'h1
`define EFTS_LIMIT_RST 16'h0020

// Sizes and timing
`define EFTS_SEG_OCTETS 240
`define EFTS_SECTION_OCTETS 64000
`define EFTS_EVT_OCTETS 16
`define EFTS_DEPTH 64
`define EFTS_TIMEOUT_MS 1000
`define EFTS_CLK_MHZ 100

`endif

//--- core/efts_pkg.sv
package efts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECTED = 3'b001,
    ST_CALLED = 3'b010,
    ST_SEND = 3'b011,
    ST_WAIT_SEC = 3'b100,
    ST_WAIT_FILE = 3'b101
  } efts_state_t;

  typedef struct packed {
    logic [7:0] ti;
    logic [31:0] value;
    logic [55:0] stamp;
  } efts_entry_t;

endpackage

//--- core/efts_buf_if.sv
`timescale 1ns/1ns
interface efts_buf_if
  import efts_pkg::*;
#(
  parameter int AW = 6
);
  logic wr_valid;
  efts_entry_t wr_entry;
  logic [7:0] wr_vsq;
  logic wr_accept;
  logic wr_reject;
  logic clear;
  logic [AW-1:0] rd_idx;
  efts_entry_t rd_entry;
  logic [AW:0] count;

  modport owner(
    output wr_valid, wr_entry, wr_vsq, clear, rd_idx,
    input wr_accept, wr_reject, rd_entry, count
  );
  modport store(
    input wr_valid, wr_entry, wr_vsq, clear, rd_idx,
    output wr_accept, wr_reject, rd_entry, count
  );
endinterface

//--- core/efts_evbuf.sv
`timescale 1ns/1ns
`include "efts_cfg.svh"
module efts_evbuf
  import efts_pkg::*;
#(
  parameter int DEPTH = `EFTS_DEPTH,
  parameter int AW = 6
)
(
  input wire logic sys_clk,
  input wire logic rst,
  efts_buf_if.store bus
);
  efts_entry_t mem [DEPTH];
  logic [AW:0] count_reg;

  wire type_ok = (bus.wr_entry.ti >= `EFTS_TI_EVT_MIN) &&
    (bus.wr_entry.ti <= `EFTS_TI_EVT_MAX);
  wire vsq_ok = bus.wr_vsq == `EFTS_VSQ_ONE;
  wire full = count_reg == (AW+1)'(DEPTH);
  wire do_wr = bus.wr_valid & type_ok & vsq_ok & ~full;
  wire [AW-1:0] wr_idx = bus.clear ? '0 : count_reg[AW-1:0];

  assign bus.wr_accept = do_wr;
  assign bus.wr_reject = bus.wr_valid & ~do_wr;
  assign bus.rd_entry = mem[bus.rd_idx];
  assign bus.count = count_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count_reg <= '0;
    else if (bus.clear)
      count_reg <= do_wr ? (AW+1)'(1) : '0;
    else if (do_wr)
      count_reg <= count_reg + (AW+1)'(1);
  end

  // Entry keeps value and acquisition stamp together
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem[wr_idx] <= bus.wr_entry;
  end
endmodule

//--- core/efts_top.sv
`timescale 1ns/1ns
`include "efts_cfg.svh"
module efts_top
  import efts_pkg::*;
#(
  parameter int DEPTH = `EFTS_DEPTH,
  parameter int TIMEOUT_CYC = `EFTS_TIMEOUT_MS * 1000 * `EFTS_CLK_MHZ
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic evt_valid,
  input wire logic [7:0] evt_ti,
  input wire logic [7:0] evt_vsq,
  input wire logic [31:0] evt_value,
  input wire logic [55:0] evt_stamp,
  output logic evt_accepted,
  output logic evt_rejected,
  input wire logic link_up,
  input wire logic rx_valid,
  input wire logic rx_ok,
  input wire logic [7:0] rx_ti,
  input wire logic [7:0] rx_qual,
  input wire logic [15:0] rx_name,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_ti,
  output logic [7:0] tx_qual,
  output logic [15:0] tx_name,
  output logic tx_seg_start,
  output efts_entry_t tx_entry
);
  localparam int AW = $clog2(DEPTH);
  localparam int SEG_ENTRIES = `EFTS_SEG_OCTETS / `EFTS_EVT_OCTETS;
  localparam logic [7:0] SEG_N = 8'(SEG_ENTRIES);

  generate
    if (DEPTH < 2 || DEPTH != (1 << AW) ||
        DEPTH * `EFTS_EVT_OCTETS > `EFTS_SECTION_OCTETS ||
        SEG_ENTRIES < 1 || TIMEOUT_CYC < 1)
      $error("efts_top: unsupported parameter values");
  endgenerate

  efts_buf_if #(.AW(AW)) buf_bus ();

  efts_evbuf #(.DEPTH(DEPTH), .AW(AW)) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus(buf_bus)
  );

  efts_state_t state_reg, state_next;
  logic en_reg;
  logic [15:0] limit_reg;
  logic [15:0] rejects_reg;
  logic [15:0] aborts_reg;
  logic dir_sent_reg, dir_sent_next;
  logic abort_reg;
  logic [31:0] timer_reg;
  logic [AW:0] rd_reg, rd_next;
  logic [7:0] seg_reg, seg_next;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic flush_reg;
  logic tx_load;
  logic [7:0] tx_ti_next, tx_qual_next;
  logic tx_seg_next;
  logic clear_next;
  logic abort_done;

  // Bus decode
  wire ahb_addr_ph = hsel & htrans[1] & hready;
  wire ahb_wr = wr_pend_reg;
  wire [7:0] rd_ofs = haddr[7:0];
  wire file_ready = {16'h0000, limit_reg} <
    {(32-(AW+1))'(0), buf_bus.count};
  wire [31:0] status_word = {(16-(AW+1))'(0), buf_bus.count, 9'h000,
    link_up, abort_reg, dir_sent_reg, file_ready, state_reg};
  wire [31:0] rd_mux =
    (rd_ofs == `EFTS_OFS_CTRL) ? {31'h0, en_reg} :
    (rd_ofs == `EFTS_OFS_LIMIT) ? {16'h0000, limit_reg} :
    (rd_ofs == `EFTS_OFS_STATUS) ? status_word :
    (rd_ofs == `EFTS_OFS_REJECTS) ? {16'h0000, rejects_reg} :
    (rd_ofs == `EFTS_OFS_ABORTS) ? {16'h0000, aborts_reg} : 32'h0;
  wire wr_ctrl = ahb_wr & (addr_reg == `EFTS_OFS_CTRL);
  wire wr_limit = ahb_wr & (addr_reg == `EFTS_OFS_LIMIT);

  // Sequencer decode
  wire active = state_reg != ST_IDLE;
  wire tx_free = ~tx_valid | tx_ready;
  wire rx_ctl = rx_valid & rx_ok;
  wire rx_bad = rx_valid & ~rx_ok;
  wire is_call = rx_ctl & (rx_ti == `EFTS_TI_CALL);
  wire is_ack = rx_ctl & (rx_ti == `EFTS_TI_ACK);
  wire sel_cmd = is_call & (rx_qual == `EFTS_SCQ_SELECT);
  wire call_file = is_call & (rx_qual == `EFTS_SCQ_CALL_FILE);
  wire call_sec = is_call & (rx_qual == `EFTS_SCQ_CALL_SEC);
  wire deact = is_call & (rx_qual == `EFTS_SCQ_DEACT);
  wire name_ok = rx_name == `EFTS_NAME_SOE;
  wire dir_due = file_ready & ~dir_sent_reg & en_reg;
  wire timed_out = active & (timer_reg == 32'h0);
  wire abort_req = abort_reg | (active & (rx_bad | timed_out));
  wire more_entries = rd_reg < buf_bus.count;
  wire seg_wrap = seg_reg == SEG_N;
  wire tx_hs = tx_valid & tx_ready;

  assign buf_bus.wr_valid = evt_valid & ~active & en_reg;
  assign buf_bus.wr_entry = '{ti: evt_ti, value: evt_value, stamp: evt_stamp};
  assign buf_bus.wr_vsq = evt_vsq;
  assign buf_bus.rd_idx = rd_reg[AW-1:0];
  assign buf_bus.clear = clear_next | flush_reg;

  always_comb
  begin
    state_next = state_reg;
    tx_load = 1'b0;
    tx_ti_next = `EFTS_TI_LAST;
    tx_qual_next = 8'h00;
    tx_seg_next = 1'b0;
    rd_next = rd_reg;
    seg_next = seg_reg;
    clear_next = 1'b0;
    dir_sent_next = dir_sent_reg & file_ready;
    abort_done = 1'b0;
    if (!link_up)
      state_next = ST_IDLE;
    else if (abort_req)
    begin
      if (tx_free)
      begin
        tx_load = 1'b1;
        tx_ti_next = `EFTS_TI_LAST;
        tx_qual_next = `EFTS_LSQ_DEACT;
        state_next = ST_IDLE;
        abort_done = 1'b1;
      end
    end
    else if (deact)
      state_next = ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (sel_cmd && tx_free)
          begin
            tx_load = 1'b1;
            tx_ti_next = `EFTS_TI_FILE_READY;
            if (name_ok && file_ready && en_reg)
            begin
              tx_qual_next = `EFTS_RDY_POS;
              state_next = ST_SELECTED;
            end
            else
              tx_qual_next = `EFTS_RDY_NEG;
          end
          else if (dir_due && tx_free)
          begin
            tx_load = 1'b1;
            tx_ti_next = `EFTS_TI_DIRECTORY;
            dir_sent_next = 1'b1;
          end
        end
        ST_SELECTED:
        begin
          if (call_file && tx_free)
          begin
            tx_load = 1'b1;
            tx_ti_next = `EFTS_TI_SECTION_READY;
            tx_qual_next = `EFTS_RDY_POS;
            state_next = ST_CALLED;
          end
        end
        ST_CALLED, ST_WAIT_SEC, ST_WAIT_FILE:
        begin
          if (call_sec)
          begin
            rd_next = '0;
            seg_next = 8'h00;
            state_next = ST_SEND;
          end
          else if (is_ack && state_reg == ST_WAIT_SEC && tx_free)
          begin
            if (rx_qual == `EFTS_AFQ_SEC_POS)
            begin
              tx_load = 1'b1;
              tx_ti_next = `EFTS_TI_LAST;
              tx_qual_next = `EFTS_LSQ_LAST_SEC;
              state_next = ST_WAIT_FILE;
            end
            else
              state_next = ST_IDLE;
          end
          else if (is_ack && state_reg == ST_WAIT_FILE)
          begin
            clear_next = rx_qual == `EFTS_AFQ_FILE_POS;
            state_next = ST_IDLE;
          end
        end
        ST_SEND:
        begin
          if (tx_free)
          begin
            tx_load = 1'b1;
            if (more_entries)
            begin
              tx_ti_next = `EFTS_TI_SEGMENT;
              tx_seg_next = (seg_reg == 8'h00) | seg_wrap;
              seg_next = seg_wrap ? 8'h01 : seg_reg + 8'h01;
              rd_next = rd_reg + (AW+1)'(1);
            end
            else
            begin
              tx_ti_next = `EFTS_TI_LAST;
              tx_qual_next = `EFTS_LSQ_LAST_SEG;
              state_next = ST_WAIT_SEC;
            end
          end
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_reg <= '0;
      seg_reg <= 8'h00;
      dir_sent_reg <= 1'b0;
    end
    else
    begin
      rd_reg <= rd_next;
      seg_reg <= seg_next;
      dir_sent_reg <= dir_sent_next;
    end
  end

  // Abort held until the deactivation can be sent
  always_ff @(posedge sys_clk)
  begin
    if (rst || !link_up || abort_done)
      abort_reg <= 1'b0;
    else if (active && (rx_bad || timed_out))
      abort_reg <= 1'b1;
  end

  // Watchdog on the awaited control ASDU
  always_ff @(posedge sys_clk)
  begin
    if (rst || !active || rx_valid || tx_hs)
      timer_reg <= 32'(TIMEOUT_CYC);
    else if (timer_reg != 32'h0)
      timer_reg <= timer_reg - 32'h1;
  end

  // Transmit slot held until the link takes it
  always_ff @(posedge sys_clk)
  begin
    if (rst || !link_up)
      tx_valid <= 1'b0;
    else if (tx_load)
      tx_valid <= 1'b1;
    else if (tx_ready)
      tx_valid <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_ti <= 8'h00;
      tx_qual <= 8'h00;
      tx_name <= 16'h0000;
      tx_seg_start <= 1'b0;
      tx_entry <= '0;
    end
    else if (tx_load)
    begin
      tx_ti <= tx_ti_next;
      tx_qual <= tx_qual_next;
      tx_name <= `EFTS_NAME_SOE;
      tx_seg_start <= tx_seg_next;
      tx_entry <= buf_bus.rd_entry;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      evt_accepted <= 1'b0;
      evt_rejected <= 1'b0;
      rejects_reg <= 16'h0000;
      aborts_reg <= 16'h0000;
    end
    else
    begin
      evt_accepted <= buf_bus.wr_accept;
      evt_rejected <= evt_valid & ~buf_bus.wr_accept;
      if (evt_valid && !buf_bus.wr_accept)
        rejects_reg <= rejects_reg + 16'h0001;
      if (abort_done)
        aborts_reg <= aborts_reg + 16'h0001;
    end
  end

  // Bus slave, zero wait states
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= ahb_addr_ph & hwrite;
      if (ahb_addr_ph)
        addr_reg <= haddr[7:0];
      if (ahb_addr_ph && !hwrite)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      en_reg <= `EFTS_EN_RST;
      limit_reg <= `EFTS_LIMIT_RST;
      flush_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        en_reg <= hwdata[`EFTS_CTRL_EN_BIT];
      if (wr_limit)
        limit_reg <= hwdata[15:0];
      flush_reg <= wr_ctrl & hwdata[`EFTS_CTRL_FLUSH_BIT] & ~active;
    end
  end
endmodule

//--- dv/efts_top_sva.sv
`timescale 1ns/1ns
module efts_chk
  import efts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic evt_valid,
  input wire logic [7:0] evt_ti,
  input wire logic [7:0] evt_vsq,
  input wire logic evt_accepted,
  input wire logic evt_rejected,
  input wire logic link_up,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_ti,
  input wire logic [7:0] tx_qual,
  input wire logic tx_seg_start,
  input wire efts_entry_t tx_entry
);
  logic [4:0] seg_cnt_reg;
  wire seg_go = tx_valid && tx_ready && tx_ti == 8'h7D;
  always_ff @(posedge sys_clk)
  begin
    if (rst || (seg_go && tx_seg_start))
      seg_cnt_reg <= 5'h00;
    else if (seg_go)
      seg_cnt_reg <= seg_cnt_reg + 5'h01;
  end
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_TYPE_RANGE: assert property (evt_valid &&
    !(evt_ti inside {[8'h1E:8'h28]}) |=> evt_rejected && !evt_accepted)
    else $error("bad type stored");
  AST_VSQ_ONE: assert property (evt_valid && evt_vsq != 8'h01
    |=> evt_rejected) else $error("bad vsq stored");
  AST_EVT_ANSWER: assert property (evt_valid
    |=> evt_accepted ^ evt_rejected) else $error("no event answer");
  AST_EVT_QUIET: assert property (!evt_valid
    |=> !evt_accepted && !evt_rejected) else $error("stray answer");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready && link_up
    |=> tx_valid && $stable({tx_ti, tx_qual, tx_entry}))
    else $error("tx changed before taken");
  AST_LINK_DROP: assert property (!link_up |=> !tx_valid)
    else $error("tx during link loss");
  AST_TX_TYPES: assert property (tx_valid |-> tx_ti inside
    {8'h78, 8'h79, 8'h7B, 8'h7D, 8'h7E}) else $error("bad tx type");
  AST_SEG_EVENT: assert property (tx_valid && tx_ti == 8'h7D
    |-> tx_entry.ti inside {[8'h1E:8'h28]}) else $error("bad segment");
  AST_LAST_QUAL: assert property (tx_valid && tx_ti == 8'h7B
    |-> tx_qual inside {8'h01, 8'h02, 8'h03}) else $error("bad last qual");
  AST_SEG_BUDGET: assert property (seg_go && !tx_seg_start
    |-> seg_cnt_reg < 5'h0E) else $error("segment too long");
endmodule
bind efts_top efts_chk chk (.sys_clk, .rst, .evt_valid, .evt_ti,
  .evt_vsq, .evt_accepted, .evt_rejected, .link_up, .tx_valid,
  .tx_ready, .tx_ti, .tx_qual, .tx_seg_start, .tx_entry);

//--- dv/efts_master.sv
`timescale 1ns/1ns
module efts_master
(
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_ti,
  input wire logic [7:0] tx_qual,
  input wire logic tx_seg_start,
  input wire logic [95:0] tx_entry,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_ok,
  output logic [7:0] rx_ti,
  output logic [7:0] rx_qual,
  output logic [15:0] rx_name
);
  logic [15:0] got[$];
  logic [95:0] segs[$];
  int n_start = 0;
  initial
  begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_ok = 1'b1;
    rx_ti = 8'h00;
    rx_qual = 8'h00;
    rx_name = 16'h0000;
  end
  // Slow mode stalls every other cycle
  always @(posedge sys_clk)
  begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready)
    begin
      got.push_back({tx_ti, tx_qual});
      if (tx_ti == 8'h7D)
        segs.push_back(tx_entry);
      if (tx_ti == 8'h7D && tx_seg_start)
        n_start++;
    end
  end
  // Control ASDU for one cycle, then lines scrambled
  task automatic send(input logic [7:0] ti, input logic [7:0] qual,
    input logic [15:0] name, input logic ok);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_ok <= ok;
    rx_ti <= ti;
    rx_qual <= qual;
    rx_name <= name;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_ok <= ~ok;
    rx_ti <= ~ti;
    rx_qual <= ~qual;
    rx_name <= ~name;
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import efts_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, evt_accepted, evt_rejected, tx_valid;
  logic tx_ready, tx_seg_start, rx_valid, rx_ok;
  logic evt_valid = 1'b0;
  logic [7:0] evt_ti = 8'h0;
  logic [7:0] evt_vsq = 8'h0;
  logic [31:0] evt_value = 32'h0;
  logic [55:0] evt_stamp = 56'h0;
  logic link_up = 1'b1;
  logic slow = 1'b0;
  logic [7:0] rx_ti, rx_qual, tx_ti, tx_qual;
  logic [15:0] rx_name, tx_name;
  efts_entry_t tx_entry;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int i;
  always #5 sys_clk = ~sys_clk;
  efts_top #(.DEPTH(64), .TIMEOUT_CYC(50)) dut (.sys_clk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .evt_valid, .evt_ti, .evt_vsq,
    .evt_value, .evt_stamp, .evt_accepted, .evt_rejected, .link_up,
    .rx_valid, .rx_ok, .rx_ti, .rx_qual, .rx_name, .tx_valid,
    .tx_ready, .tx_ti, .tx_qual, .tx_name, .tx_seg_start, .tx_entry);
  efts_master m (.sys_clk, .slow, .tx_valid, .tx_ti, .tx_qual, .tx_seg_start,
    .tx_entry, .tx_ready, .rx_valid, .rx_ok, .rx_ti, .rx_qual,
    .rx_name);
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic ev(input logic [7:0] ti, input logic [7:0] vsq,
    input logic acc);
    @(posedge sys_clk);
    evt_valid <= 1'b1;
    evt_ti <= ti;
    evt_vsq <= vsq;
    evt_value <= evt_value + 32'h1;
    evt_stamp <= evt_stamp + 56'h100;
    @(posedge sys_clk);
    evt_valid <= 1'b0;
    #1;
    chk({31'h0, evt_accepted}, {31'h0, acc});
    chk({31'h0, evt_rejected}, {31'h0, ~acc});
  endtask
  task automatic exp_tx(input logic [15:0] e, input logic [15:0] mk);
    int k;
    for (k = 0; k < 200 && m.got.size() == 0; k++)
      @(posedge sys_clk);
    chk({16'h0, (m.got.size() ? m.got.pop_front() : ~e) & mk},
      {16'h0, e & mk});
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd, 32'h20);
    ahb(1'b0, 32'h14, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h4, 32'h3, rd);
    ev(8'h1D, 8'h01, 1'b0);
    ev(8'h29, 8'h01, 1'b0);
    ev(8'h1E, 8'h02, 1'b0);
    for (i = 0; i < 3; i++)
      ev(8'h1E + 8'(i * 5), 8'h01, 1'b1);
    repeat (10) @(posedge sys_clk);
    chk(32'(m.got.size()), 32'h0);
    ev(8'h21, 8'h01, 1'b1);
    exp_tx(16'h7E00, 16'hFF00);
    ahb(1'b0, 32'hC, 32'h0, rd);
    chk(rd, 32'h3);
    slow <= 1'b1;
    m.send(8'h7A, 8'h01, 16'h0005, 1'b1);
    exp_tx(16'h7880, 16'hFFFF);
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    m.send(8'h7A, 8'h02, 16'h0003, 1'b1);
    exp_tx(16'h7900, 16'hFFFF);
    m.send(8'h7A, 8'h06, 16'h0003, 1'b1);
    for (i = 0; i < 4; i++)
      exp_tx(16'h7D00, 16'hFF00);
    exp_tx(16'h7B03, 16'hFFFF);
    for (i = 0; i < 4; i++)
    begin
      chk({24'h0, m.segs[i][95:88]},
        (i < 3) ? 32'h1E + 32'(i * 5) : 32'h21);
      chk(m.segs[i][87:56], 32'(i + 4));
      chk(m.segs[i][31:0], 32'((i + 4) * 256));
    end
    chk(32'(m.n_start), 32'h1);
    chk({hresp, hreadyout, 14'h0, tx_name}, 32'h4000_0003);
    m.send(8'h7C, 8'h03, 16'h0003, 1'b1);
    exp_tx(16'h7B01, 16'hFFFF);
    m.send(8'h7C, 8'h01, 16'h0003, 1'b1);
    repeat (4) @(posedge sys_clk);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({rd[31:16], 13'h0, rd[2:0]}, 32'h0);
    for (i = 0; i < 4; i++)
      ev(8'h22, 8'h01, 1'b1);
    exp_tx(16'h7E00, 16'hFF00);
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    m.send(8'h7A, 8'h02, 16'h0003, 1'b0);
    exp_tx(16'h7B02, 16'hFFFF);
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    exp_tx(16'h7B02, 16'hFFFF);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h2);
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    link_up <= 1'b0;
    m.send(8'h7A, 8'h02, 16'h0003, 1'b1);
    repeat (5) @(posedge sys_clk);
    chk(32'(m.got.size()), 32'h0);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({25'h0, rd[6], 3'h0, rd[2:0]}, 32'h0);
    link_up <= 1'b1;
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    m.send(8'h7A, 8'h03, 16'h0003, 1'b1);
    repeat (4) @(posedge sys_clk);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({29'h0, rd[2:0]}, 32'h0);
    m.send(8'h7A, 8'h01, 16'h0003, 1'b1);
    exp_tx(16'h7800, 16'hFFFF);
    m.send(8'h7A, 8'h02, 16'h0003, 1'b1);
    exp_tx(16'h7900, 16'hFFFF);
    for (i = 0; i < 2; i++)
    begin
      m.send(8'h7A, 8'h06, 16'h0003, 1'b1);
      repeat (4) exp_tx(16'h7D00, 16'hFF00);
      exp_tx(16'h7B03, 16'hFFFF);
    end
    chk(32'(m.n_start), 32'h3);
    m.send(8'h7C, 8'h04, 16'h0003, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk(32'(m.got.size()), 32'h0);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({rd[31:16], 13'h0, rd[2:0]}, 32'h0004_0000);
    report_and_stop();
  end
endmodule
